// file: logic/rrd_detector.sv
/*
  Beat interval detector: finds R events in channel samples, measures
  the interval between them, and raises a beat event flag.
  Assumes samples, channel enable and clock select come from core clock logic.
*/
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module rrd_detector #(
  parameter logic [19:0] TICK_CYC_00 = 20'(rrd_pkg::TICK_NS_00 / rrd_pkg::CLK_PERIOD_NS),
  parameter logic [19:0] TICK_CYC_01 = 20'(rrd_pkg::TICK_NS_01 / rrd_pkg::CLK_PERIOD_NS),
  parameter logic [19:0] TICK_CYC_10 = 20'(rrd_pkg::TICK_NS_10 / rrd_pkg::CLK_PERIOD_NS),
  parameter logic [19:0] TICK_CYC_11 = 20'(rrd_pkg::TICK_NS_11 / rrd_pkg::CLK_PERIOD_NS)
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [6:0] addr_i,
  input wire logic [23:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [23:0] rd_data_o,
  input wire logic sample_valid_i,
  input wire logic signed [17:0] sample_data_i,
  input wire logic channel_enable_i,
  input wire logic [1:0] master_clock_select_i,
  output logic irq_o,
  output logic second_irq_o
);

  // ************************************************************
  // Registers
  // ************************************************************
  logic [23:0] cfg_a;
  logic [23:0] cfg_b;
  logic [1:0] clear_mode;
  logic [1:0] status;
  logic [1:0] irq_mask;
  logic [13:0] interval_val;
  logic [13:0] ival_cnt;
  logic [13:0] ival_avg;
  logic [15:0] peak_avg;
  logic [15:0] peak_track;
  logic [4:0] win_left;
  logic [3:0] auto_shift;
  logic beat_age;
  logic tick;

  logic det_on;
  logic wr_status;
  logic rd_status;
  logic rd_interval;
  logic [3:0] gain_code;
  logic [3:0] shift;
  logic [16:0] mag;
  logic [31:0] gained;
  logic [15:0] env;
  logic [19:0] thresh_full;
  logic [15:0] thresh;
  logic [16:0] dyn_full;
  logic [13:0] hold_dyn;
  logic [13:0] hold_min;
  logic [13:0] hold_eff;
  logic hold_ok;
  logic r_event;
  logic cnt_wrap;
  logic win_end;
  logic [4:0] win_len;
  logic [13:0] next_ival_avg;
  logic [15:0] next_peak_avg;
  logic [15:0] peak_sample;
  logic beat_clr;
  logic [1:0] next_status;
  logic [1:0] next_irq_mask;

  // ************************************************************
  // Decode and enables
  // ************************************************************
  assign det_on = cfg_a[rrd_pkg::EN_BIT] & channel_enable_i;
  assign wr_status = wr_en_i && (addr_i == rrd_pkg::ADDR_STATUS);
  assign rd_status = rd_en_i && (addr_i == rrd_pkg::ADDR_STATUS);
  assign rd_interval = rd_en_i && (addr_i == rrd_pkg::ADDR_INTERVAL);

  rrd_tick_gen #(
    .CYC_00(TICK_CYC_00),
    .CYC_01(TICK_CYC_01),
    .CYC_10(TICK_CYC_10),
    .CYC_11(TICK_CYC_11)
  ) u_tick (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(det_on),
    .clk_sel_i(master_clock_select_i),
    .tick_o(tick)
  );

  // ************************************************************
  // Gain and envelope
  // ************************************************************
  assign gain_code = cfg_a[rrd_pkg::GAIN_LSB +: 4];
  assign shift = (gain_code == rrd_pkg::GAIN_AUTO) ? auto_shift : gain_code;

  always_comb begin
    mag = sample_data_i[17] ? 17'(-sample_data_i) : sample_data_i[16:0];
    gained = {15'h0, mag} << shift;
    env = (gained[31:16] != 16'h0) ? rrd_pkg::ENV_FULL : gained[15:0];
  end

  // ************************************************************
  // Threshold, hold-off and event
  // ************************************************************
  always_comb begin
    thresh_full = peak_avg * ({16'h0, cfg_a[rrd_pkg::PEAK_THRESHOLD_SCALE_LSB +: 4]} + 20'h1);
    thresh = thresh_full[19:4];
    dyn_full = ival_avg * cfg_b[rrd_pkg::HOLDOFF_DYNAMIC_SCALE_LSB +: 3];
    hold_dyn = dyn_full[16:3];
    hold_min = {8'h0, cfg_b[rrd_pkg::MINIMUM_HOLDOFF_LSB +: 6]};
    hold_eff = (hold_dyn > hold_min) ? hold_dyn : hold_min;
  end

  assign hold_ok = (ival_cnt >= hold_eff);
  assign r_event = det_on && sample_valid_i && hold_ok && (env > thresh);
  assign cnt_wrap = det_on && tick && (ival_cnt == 14'h3fff) && !r_event;
  assign win_len = rrd_pkg::QRS_WINDOW_WIDTH_BASE + {cfg_a[rrd_pkg::QRS_WINDOW_WIDTH_LSB +: 4], 1'b0};
  assign win_end = det_on && tick && (win_left == 5'h1);
  assign peak_sample = (sample_valid_i && (env > peak_track)) ? env : peak_track;

  rrd_wavg #(
    .W(14)
  ) u_ival_avg (
    .old_i(ival_avg),
    .new_i(ival_cnt),
    .sel_i(cfg_b[rrd_pkg::RAVG_LSB +: 2]),
    .avg_o(next_ival_avg)
  );

  rrd_wavg #(
    .W(16)
  ) u_peak_avg (
    .old_i(peak_avg),
    .new_i(peak_sample),
    .sel_i(cfg_a[rrd_pkg::PEAK_AVERAGE_WEIGHT_LSB +: 2]),
    .avg_o(next_peak_avg)
  );

  // ************************************************************
  // Interval counter and interval register
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ival_cnt <= 14'h0;
      interval_val <= 14'h0;
      ival_avg <= 14'h0;
    end else if (r_event) begin
      interval_val <= ival_cnt;
      ival_avg <= next_ival_avg;
      ival_cnt <= 14'h0;
    end else if (det_on && tick) begin
      ival_cnt <= ival_cnt + 14'h1;
    end
  end

  // ************************************************************
  // Peak window and peak average
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      win_left <= 5'h0;
      peak_track <= 16'h0;
      peak_avg <= 16'h0;
    end else if (r_event) begin
      win_left <= win_len;
      peak_track <= env;
    end else if (win_end) begin
      win_left <= 5'h0;
      peak_avg <= next_peak_avg;
      peak_track <= 16'h0;
    end else if (win_left != 5'h0) begin
      peak_track <= peak_sample;
      if (det_on && tick) begin
        win_left <= win_left - 5'h1;
      end
    end
  end

  // ************************************************************
  // Automatic gain
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      auto_shift <= rrd_pkg::GAIN_AUTO_INIT;
    end else if (gain_code != rrd_pkg::GAIN_AUTO) begin
      auto_shift <= rrd_pkg::GAIN_AUTO_INIT;
    end else if (win_end) begin
      if (peak_track == rrd_pkg::ENV_FULL && auto_shift != 4'h0) begin
        auto_shift <= auto_shift - 4'h1;
      end else if (peak_track < rrd_pkg::ENV_LOW && auto_shift != rrd_pkg::GAIN_MAX) begin
        auto_shift <= auto_shift + 4'h1;
      end
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_a <= rrd_pkg::CFG_A_RESET;
      cfg_b <= rrd_pkg::CFG_B_RESET;
      clear_mode <= rrd_pkg::CLRM_RESET;
      irq_mask <= 2'h0;
    end else if (wr_en_i) begin
      case (addr_i)
        rrd_pkg::ADDR_CFG_A: cfg_a <= wr_data_i & rrd_pkg::CFG_A_MASK;
        rrd_pkg::ADDR_CFG_B: cfg_b <= wr_data_i & rrd_pkg::CFG_B_MASK;
        rrd_pkg::ADDR_INT_MGMT: clear_mode <= wr_data_i[rrd_pkg::CLRM_LSB +: 2];
        rrd_pkg::ADDR_IRQ_MASK: irq_mask <= wr_data_i[1:0];
        default: irq_mask <= irq_mask;
      endcase
    end
  end

  // ************************************************************
  // Status flags and interrupts
  // ************************************************************
  // Mask as it stands after this edge, so the interrupt output never lags a mask write
  assign next_irq_mask = (wr_en_i && (addr_i == rrd_pkg::ADDR_IRQ_MASK)) ? wr_data_i[1:0] : irq_mask;

  always_comb begin
    beat_clr = wr_status && wr_data_i[rrd_pkg::ST_BEAT];
    case (clear_mode)
      rrd_pkg::CLRM_STATUS: beat_clr = beat_clr || rd_status;
      rrd_pkg::CLRM_INTERVAL: beat_clr = beat_clr || rd_interval;
      rrd_pkg::CLRM_SELF: beat_clr = beat_clr || (beat_age && sample_valid_i);
      default: beat_clr = beat_clr;
    endcase
    next_status = status;
    if (beat_clr) begin
      next_status[rrd_pkg::ST_BEAT] = 1'b0;
    end
    if (wr_status && wr_data_i[rrd_pkg::ST_WRAP]) begin
      next_status[rrd_pkg::ST_WRAP] = 1'b0;
    end
    if (r_event) begin
      next_status[rrd_pkg::ST_BEAT] = 1'b1;
    end
    if (cnt_wrap) begin
      next_status[rrd_pkg::ST_WRAP] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status <= 2'h0;
      beat_age <= 1'b0;
      irq_o <= 1'b0;
      second_irq_o <= 1'b0;
    end else begin
      status <= next_status;
      irq_o <= |(next_status & next_irq_mask);
      second_irq_o <= next_status[rrd_pkg::ST_BEAT];
      if (r_event) begin
        beat_age <= 1'b1;
      end else if (sample_valid_i) begin
        beat_age <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 24'h0;
    end else if (rd_en_i) begin
      case (addr_i)
        rrd_pkg::ADDR_STATUS: rd_data_o <= {22'h0, status};
        rrd_pkg::ADDR_IRQ_MASK: rd_data_o <= {22'h0, irq_mask};
        rrd_pkg::ADDR_INT_MGMT: rd_data_o <= 24'({clear_mode, 4'h0});
        rrd_pkg::ADDR_CFG_A: rd_data_o <= cfg_a;
        rrd_pkg::ADDR_CFG_B: rd_data_o <= cfg_b;
        rrd_pkg::ADDR_INTERVAL: rd_data_o <= {interval_val, 10'h0};
        default: rd_data_o <= 24'h0;
      endcase
    end else begin
      rd_data_o <= 24'h0;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  chk_interval_low_zero: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    rd_interval |=> (rd_data_o[9:0] == 10'h0 && rd_data_o[23:10] == $past(interval_val)))
    else $error("interval read low bits or value wrong");

  chk_interval_load: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    r_event |=> (interval_val == $past(ival_cnt)) && status[0])
    else $error("event did not load interval and flag");

  chk_mode01_clear: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (clear_mode == 2'h1 && rd_interval && !r_event) |=> !status[0])
    else $error("flag not cleared on interval read");

  chk_mode00_clear: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (clear_mode == 2'h0 && rd_status && !r_event) |=> !status[0] && !second_irq_o)
    else $error("flag not cleared on status read");

  chk_self_clear: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (clear_mode == rrd_pkg::CLRM_SELF && status[rrd_pkg::ST_BEAT] && beat_age && sample_valid_i
      && !r_event) |=> !status[rrd_pkg::ST_BEAT])
    else $error("flag did not self clear");

  chk_wrap_noflag: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (cnt_wrap && !status[0]) |=> (ival_cnt == 14'h0) && !status[0] && status[1])
    else $error("wrap raised beat flag or did not roll");

  chk_det_off: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !(cfg_a[rrd_pkg::EN_BIT] && channel_enable_i) |-> !r_event ##1 $stable(ival_cnt))
    else $error("detector active while disabled");

  chk_cnt_restart: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    r_event |=> ival_cnt == 14'h0)
    else $error("counter not restarted at event");

  chk_holdoff_gate: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    r_event |-> (ival_cnt >= {8'h0, cfg_b[rrd_pkg::MINIMUM_HOLDOFF_LSB +: 6]}) && (ival_cnt >= hold_dyn))
    else $error("event inside hold-off");

  chk_irq_level: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    |(status & irq_mask) |-> irq_o)
    else $error("interrupt low with unmasked flag");

endmodule : rrd_detector

// file: logic/rrd_pkg.sv
/*
  Constants for the beat interval detector: register offsets, field
  positions, reset values and the detector tick timing.
  Assumes a 100 MHz core clock and a register port addressed by register number.
*/
package rrd_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [6:0] ADDR_STATUS = 7'h01;
  localparam logic [6:0] ADDR_IRQ_MASK = 7'h03;
  localparam logic [6:0] ADDR_INT_MGMT = 7'h04;
  localparam logic [6:0] ADDR_CFG_A = 7'h1d;
  localparam logic [6:0] ADDR_CFG_B = 7'h1e;
  localparam logic [6:0] ADDR_INTERVAL = 7'h25;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int QRS_WINDOW_WIDTH_LSB = 20;
  localparam int GAIN_LSB = 16;
  localparam int EN_BIT = 15;
  localparam int PEAK_AVERAGE_WEIGHT_LSB = 12;
  localparam int PEAK_THRESHOLD_SCALE_LSB = 8;
  localparam int MINIMUM_HOLDOFF_LSB = 16;
  localparam int RAVG_LSB = 12;
  localparam int HOLDOFF_DYNAMIC_SCALE_LSB = 8;
  localparam int CLRM_LSB = 4;
  localparam int IVAL_LSB = 10;
  localparam int ST_BEAT = 0;
  localparam int ST_WRAP = 1;

  // ************************************************************
  // Reset values and writable masks
  // ************************************************************
  localparam logic [23:0] CFG_A_RESET = 24'h3f2300;
  localparam logic [23:0] CFG_A_MASK = 24'hffbf00;
  localparam logic [23:0] CFG_B_RESET = 24'h202400;
  localparam logic [23:0] CFG_B_MASK = 24'h3f3700;
  localparam logic [1:0] CLRM_RESET = 2'h0;

  // ************************************************************
  // Encodings and detector constants
  // ************************************************************
  localparam logic [1:0] CLRM_STATUS = 2'h0;
  localparam logic [1:0] CLRM_INTERVAL = 2'h1;
  localparam logic [1:0] CLRM_SELF = 2'h2;
  localparam logic [3:0] GAIN_AUTO = 4'hf;
  localparam logic [3:0] GAIN_AUTO_INIT = 4'h6;
  localparam logic [3:0] GAIN_MAX = 4'he;
  localparam logic [4:0] QRS_WINDOW_WIDTH_BASE = 5'h06;
  localparam logic [15:0] ENV_FULL = 16'hffff;
  localparam logic [15:0] ENV_LOW = 16'h3fff;

  // ************************************************************
  // Detector tick: 256 master clock periods per tick
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS_00 = 7812500;
  localparam int TICK_NS_01 = 8000000;
  localparam int TICK_NS_10 = 8000000;
  localparam int TICK_NS_11 = 8008008;

endpackage : rrd_pkg

// file: logic/rrd_tick_gen.sv
/*
  Detector tick divider: one-cycle tick pulse every selected count.
  Assumes the select input and run enable are in the core clock domain.
*/
`timescale 1ns/1ps
module rrd_tick_gen #(
  parameter logic [19:0] CYC_00 = 20'd781250,
  parameter logic [19:0] CYC_01 = 20'd800000,
  parameter logic [19:0] CYC_10 = 20'd800000,
  parameter logic [19:0] CYC_11 = 20'd800800
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [1:0] clk_sel_i,
  output logic tick_o
);

  logic [19:0] cnt;
  logic [19:0] last;

  // Tick length follows the master clock selection
  always_comb begin
    case (clk_sel_i)
      2'h0: last = CYC_00 - 20'h1;
      2'h1: last = CYC_01 - 20'h1;
      2'h2: last = CYC_10 - 20'h1;
      default: last = CYC_11 - 20'h1;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 20'h0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt <= 20'h0;
      tick_o <= 1'b0;
    end else if (cnt >= last) begin
      cnt <= 20'h0;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 20'h1;
      tick_o <= 1'b0;
    end
  end

endmodule : rrd_tick_gen

// file: logic/rrd_wavg.sv
/*
  Weighted running average: (new + (w-1)*old)/w with w = 2, 4, 8 or 16.
  Assumes a purely combinational use by the caller.
*/
`timescale 1ns/1ps
module rrd_wavg #(
  parameter int W = 16
) (
  input wire logic [W-1:0] old_i,
  input wire logic [W-1:0] new_i,
  input wire logic [1:0] sel_i,
  output logic [W-1:0] avg_o
);

  logic [W+4:0] acc;
  logic [2:0] k;

  // Weight is two to the power sel plus one
  always_comb begin
    k = {1'b0, sel_i} + 3'h1;
    acc = (({5'h0, old_i} << k) - {5'h0, old_i}) + {5'h0, new_i};
    avg_o = W'(acc >> k);
  end

endmodule : rrd_wavg

// file: sim/rrd_beat_src.sv
/*
  Channel sample source standing in for the biopotential channel: one sample
  every eight cycles, a single beat sample every gap samples, zero elsewhere.
  Assumes the same core clock and reset as the detector; gap zero means no beats.
*/
`timescale 1ns/1ps
module rrd_beat_src (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] gap_i,
  input wire logic signed [17:0] amp_i,
  output logic sample_valid_o,
  output logic signed [17:0] sample_data_o
);
  logic [2:0] div;
  logic [7:0] scount;

  // ************************************************************
  // Sample strobe and beat pattern
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div <= 3'h0;
      scount <= 8'h00;
      sample_valid_o <= 1'b0;
      sample_data_o <= 18'h00000;
    end else begin
      div <= div + 3'h1;
      sample_valid_o <= (div == 3'h7);
      if (div == 3'h7) begin
        scount <= (scount + 8'h01 >= gap_i) ? 8'h00 : scount + 8'h01;
        sample_data_o <= (gap_i != 8'h00 && scount == 8'h00) ? amp_i : 18'h00000;
      end else begin
        // Data outside the strobe is junk that changes every cycle
        sample_data_o <= ~sample_data_o;
      end
    end
  end

endmodule : rrd_beat_src

// file: sim/rrd_detector_bench.sv
/*
  Self-checking bench for the beat interval detector: register port tasks,
  one task per scenario, closing report.
  Assumes a 100 MHz clock and a detector tick shortened to four cycles.
*/
`timescale 1ns/1ps
module rrd_detector_bench;
  localparam logic [19:0] TICK = 20'h00004;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [23:0] wdat = 24'h000000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic ch_en = 1'b0;
  logic [7:0] gap = 8'h32;
  logic signed [17:0] amp = 18'h003e8;
  logic [23:0] rd_data;
  logic s_valid;
  logic signed [17:0] s_data;
  logic irq;
  logic irq2;
  logic [23:0] rv;
  int n_mismatch = 0;
  int n_checks = 0;

  always #5 core_clk_i = ~core_clk_i;

  rrd_detector #(
    .TICK_CYC_00(TICK),
    .TICK_CYC_01(TICK),
    .TICK_CYC_10(TICK),
    .TICK_CYC_11(TICK)
  ) i_rrd_detector (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .addr_i(addr),
    .wr_data_i(wdat),
    .wr_en_i(wr_en),
    .rd_en_i(rd_en),
    .rd_data_o(rd_data),
    .sample_valid_i(s_valid),
    .sample_data_i(s_data),
    .channel_enable_i(ch_en),
    .master_clock_select_i(2'h1),
    .irq_o(irq),
    .second_irq_o(irq2)
  );

  rrd_beat_src i_rrd_beat_src (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .gap_i(gap),
    .amp_i(amp),
    .sample_valid_o(s_valid),
    .sample_data_o(s_data)
  );

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic near(input logic [23:0] v, input int n);
    return (v[23:10] + 14'h0001 >= 14'(n)) && (v[23:10] <= 14'(n + 1));
  endfunction : near

  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdat <= d;
    wr_en <= 1'b1;
    @(posedge core_clk_i);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [6:0] a);
    @(posedge core_clk_i);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk_i);
    rd_en <= 1'b0;
    #1 rv = rd_data;
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : settle

  task automatic wait_beat();
    int i = 0;
    while (irq2 !== 1'b1 && i < 2000) begin
      @(posedge core_clk_i);
      i++;
    end
    #1;
    check({23'h0, irq2}, 24'h000001);
    if (irq2 !== 1'b1) begin
      tally_and_finish();
    end
  endtask : wait_beat

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset_values();
    logic [6:0] a [7];
    logic [23:0] e [7];
    a = '{rrd_pkg::ADDR_CFG_A, rrd_pkg::ADDR_CFG_B, rrd_pkg::ADDR_INTERVAL,
          rrd_pkg::ADDR_STATUS, rrd_pkg::ADDR_IRQ_MASK, rrd_pkg::ADDR_INT_MGMT, 7'h10};
    e = '{rrd_pkg::CFG_A_RESET, rrd_pkg::CFG_B_RESET, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0};
    foreach (a[i]) begin
      rd(a[i]);
      check(rv, e[i]);
    end
    check({22'h0, irq, irq2}, 24'h000000);
  endtask : t_reset_values

  task automatic t_cfg_rw();
    wr(rrd_pkg::ADDR_CFG_A, 24'hffffff);
    rd(rrd_pkg::ADDR_CFG_A);
    check(rv, rrd_pkg::CFG_A_MASK);
    wr(rrd_pkg::ADDR_CFG_B, 24'hffffff);
    rd(rrd_pkg::ADDR_CFG_B);
    check(rv, rrd_pkg::CFG_B_MASK);
    wr(rrd_pkg::ADDR_CFG_B, 24'h000000);
    rd(rrd_pkg::ADDR_CFG_B);
    check(rv, 24'h000000);
  endtask : t_cfg_rw

  task automatic t_enable();
    wr(rrd_pkg::ADDR_CFG_A, 24'h302300);
    wr(rrd_pkg::ADDR_CFG_B, 24'h022000);
    ch_en <= 1'b1;
    settle(1000);
    rd(rrd_pkg::ADDR_STATUS);
    check(rv, 24'h000000);
    wr(rrd_pkg::ADDR_CFG_A, 24'h30a300);
    ch_en <= 1'b0;
    settle(1000);
    rd(rrd_pkg::ADDR_STATUS);
    check(rv, 24'h000000);
  endtask : t_enable

  task automatic t_interval();
    wr(rrd_pkg::ADDR_INT_MGMT, 24'h000000);
    wr(rrd_pkg::ADDR_IRQ_MASK, 24'h000001);
    ch_en <= 1'b1;
    wait_beat();
    settle(1);
    check({23'h0, irq}, 24'h000001);
    rd(rrd_pkg::ADDR_STATUS);
    check(rv, 24'h000001);
    settle(2);
    check({22'h0, irq, irq2}, 24'h000000);
    wait_beat();
    rd(rrd_pkg::ADDR_INTERVAL);
    check({14'h0, rv[9:0]}, 24'h000000);
    check({23'h0, near(rv, 100)}, 24'h000001);
    rd(rrd_pkg::ADDR_STATUS);
  endtask : t_interval

  task automatic t_clear_mode(input logic [1:0] m);
    wr(rrd_pkg::ADDR_INT_MGMT, {18'h0, m, 4'h0});
    wait_beat();
    settle(12);
    check({23'h0, irq2}, {23'h0, m != 2'h2});
    rd(rrd_pkg::ADDR_STATUS);
    settle(2);
    check({23'h0, irq2}, {23'h0, m[0]});
    rd(rrd_pkg::ADDR_INTERVAL);
    settle(2);
    check({23'h0, irq2}, {23'h0, &m});
    if (m == 2'h3) begin
      check({23'h0, irq}, 24'h000001);
      wr(rrd_pkg::ADDR_IRQ_MASK, 24'h000000);
      settle(2);
      check({22'h0, irq, irq2}, 24'h000001);
      wr(rrd_pkg::ADDR_IRQ_MASK, 24'h000001);
      wr(rrd_pkg::ADDR_STATUS, 24'h000003);
      settle(2);
      check({22'h0, irq, irq2}, 24'h000000);
    end
  endtask : t_clear_mode

  task automatic t_holdoff();
    wr(rrd_pkg::ADDR_INT_MGMT, 24'h000000);
    wr(rrd_pkg::ADDR_CFG_B, 24'h3f2000);
    gap <= 8'h14;
    amp <= 18'h3fc18;
    wait_beat();
    rd(rrd_pkg::ADDR_STATUS);
    wait_beat();
    rd(rrd_pkg::ADDR_STATUS);
    wait_beat();
    rd(rrd_pkg::ADDR_INTERVAL);
    check({23'h0, near(rv, 80)}, 24'h000001);
  endtask : t_holdoff

  // Small static hold-off, fast interval average, dynamic scale 7/8:
  // beats every 40 ticks must still be refused, so the interval reads 80
  task automatic t_dyn_holdoff();
    wr(rrd_pkg::ADDR_CFG_B, 24'h080700);
    rd(rrd_pkg::ADDR_STATUS);
    wait_beat();
    rd(rrd_pkg::ADDR_STATUS);
    wait_beat();
    rd(rrd_pkg::ADDR_INTERVAL);
    check({23'h0, near(rv, 80)}, 24'h000001);
  endtask : t_dyn_holdoff

  task automatic t_wrap();
    gap <= 8'h00;
    settle(400);
    rd(rrd_pkg::ADDR_STATUS);
    settle(66000);
    rd(rrd_pkg::ADDR_STATUS);
    check(rv, 24'h000002);
    check({23'h0, irq2}, 24'h000000);
  endtask : t_wrap

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_reset_values();
    t_cfg_rw();
    t_enable();
    t_interval();
    for (int m = 0; m < 4; m++) begin
      t_clear_mode(2'(m));
    end
    t_holdoff();
    t_dyn_holdoff();
    t_wrap();
    tally_and_finish();
  end

endmodule : rrd_detector_bench
